// ### prog_port_pkg.sv
/*
 * shared constants for the synthesizer serial programming port:
 * frame layout, phase counts and the readback pin select encoding.
 * assumes nothing of its surroundings.
 */
package prog_port_pkg;
    localparam int FRAME_BITS = 24;
    localparam int ADDR_BITS  = 7;
    localparam int DATA_BITS  = 16;
    localparam int CNT_BITS   = 5;
    // flag bit is the first bit of the frame
    localparam logic [CNT_BITS-1:0] FLAG_BIT_CNT = 5'h01;
    // address phase ends after flag plus address
    localparam logic [CNT_BITS-1:0] ADDR_END_CNT = 5'h08;
    localparam logic [CNT_BITS-1:0] FRAME_END_CNT = 5'h18;
    localparam logic FLAG_WRITE = 1'b0;
    localparam logic FLAG_READ  = 1'b1;
    localparam logic PIN_SEL_READBACK = 1'b0;
    localparam logic PIN_SEL_LOCK     = 1'b1;
    // host side serial clock divider, half period in system clocks
    localparam int HALF_PERIOD_DEF = 5;
endpackage

// ### prog_port_if.sv
/*
 * link between the serial programming host and the synthesizer port.
 * assumes the bench drives no pin; every pin has one driver.
 */
`timescale 1ns/1ps
interface prog_port_if;
    logic sclk;
    logic select_bar_in;
    logic serial_data_in;
    logic readback_out_pin;

    modport host (
        output sclk,
        output select_bar_in,
        output serial_data_in,
        input  readback_out_pin
    );
    modport dev (
        input  sclk,
        input  select_bar_in,
        input  serial_data_in,
        output readback_out_pin
    );
endinterface

// ### prog_port_dev.sv
/*
 * device end of the serial programming port: shifts write frames in,
 * returns readback data on the shared readback/lock pin.
 * assumes the host keeps the frame format and select framing; the
 * link logic runs on the serial clock only, user side on clk.
 */
`timescale 1ns/1ps
module prog_port_dev
    import prog_port_pkg::*;
(
    // system side
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    clk_en,
    // link
    prog_port_if.dev                     link,
    // register file access
    input  wire logic                    readback_pin_select,
    input  wire logic                    lock_detect,
    input  wire logic [DATA_BITS-1:0]    rd_data,
    output logic      [ADDR_BITS-1:0]    rd_addr,
    output logic                         wr_valid,
    output logic      [ADDR_BITS-1:0]    wr_addr,
    output logic      [DATA_BITS-1:0]    wr_data
);
    import prog_port_pkg::*;

    // next shift value with one new bit at the bottom
    function automatic logic [FRAME_BITS-1:0] shift_in(
        input logic [FRAME_BITS-1:0] sr,
        input logic                  b
    );
        return {sr[FRAME_BITS-2:0], b};
    endfunction

    // readback data phase: flag one and address complete
    function automatic logic in_rd_data(
        input logic                rd,
        input logic [CNT_BITS-1:0] c
    );
        return rd && (c >= ADDR_END_CNT);
    endfunction

    // readback register moved up by one bit
    function automatic logic [DATA_BITS-1:0] shift_out(
        input logic [DATA_BITS-1:0] v
    );
        return {v[DATA_BITS-2:0], 1'b0};
    endfunction

    // rising edge that completes the frame
    function automatic logic last_rise(
        input logic [CNT_BITS-1:0] c
    );
        return c == CNT_BITS'(FRAME_END_CNT - 5'h01);
    endfunction

    // link domain state; count, shift and flag reset held while deselected, toggle and hold reset by rst_b only
    logic [CNT_BITS-1:0]   cnt_r,   cnt_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic                  read_r,  read_nxt;
    logic                  done_tgl_r, done_tgl_nxt;
    logic [FRAME_BITS-1:0] hold_r,  hold_nxt;
    logic                  link_rst_b;

    assign link_rst_b = rst_b & ~link.select_bar_in;

    always_comb begin
        cnt_nxt   = cnt_r;
        shift_nxt = shift_r;
        read_nxt  = read_r;
        if (cnt_r != FRAME_END_CNT) begin
            cnt_nxt = cnt_r + 5'h01;
            if (!in_rd_data(read_r, cnt_r)) begin
                shift_nxt = shift_in(shift_r, link.serial_data_in);
            end
            if (cnt_r == 5'h00) begin
                read_nxt = (link.serial_data_in == FLAG_READ);
            end
        end
    end

    // only flag zero frames commit a write
    // cnt_r held at zero while deselected, so stray clocks commit nothing
    always_comb begin
        done_tgl_nxt = done_tgl_r;
        hold_nxt     = hold_r;
        if (last_rise(cnt_r) && !read_r) begin
            hold_nxt     = shift_in(shift_r, link.serial_data_in);
            done_tgl_nxt = ~done_tgl_r;
        end
    end

    // select high holds link logic idle
    always_ff @(posedge link.sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            cnt_r   <= '0;
            shift_r <= '0;
            read_r  <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            shift_r <= shift_nxt;
            read_r  <= read_nxt;
        end
    end

    // survives deselect so the toggle reaches clk domain
    always_ff @(posedge link.sclk or negedge rst_b) begin
        if (!rst_b) begin
            done_tgl_r <= 1'b0;
            hold_r     <= '0;
        end else begin
            done_tgl_r <= done_tgl_nxt;
            hold_r     <= hold_nxt;
        end
    end

    // address seen by the register file; steady during readback data phase
    assign rd_addr = shift_r[ADDR_BITS-1:0];

    // readback output, falling edge launch
    logic [DATA_BITS-1:0] out_sr_r, out_sr_nxt;
    logic                 out_bit_r, out_bit_nxt;

    always_comb begin
        out_sr_nxt  = out_sr_r;
        out_bit_nxt = 1'b0;
        if (in_rd_data(read_r, cnt_r)) begin
            // new bit after each falling edge
            if (cnt_r == ADDR_END_CNT) begin
                out_bit_nxt = rd_data[DATA_BITS-1];
                out_sr_nxt  = shift_out(rd_data);
            end else begin
                out_bit_nxt = out_sr_r[DATA_BITS-1];
                out_sr_nxt  = shift_out(out_sr_r);
            end
        end
    end

    always_ff @(negedge link.sclk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            out_sr_r  <= '0;
            out_bit_r <= 1'b0;
        end else begin
            out_sr_r  <= out_sr_nxt;
            out_bit_r <= out_bit_nxt;
        end
    end

    // lock flag comes from another clock; two flops before the pin mux
    logic [1:0] lock_sync_r, lock_sync_nxt;

    always_comb begin
        lock_sync_nxt = {lock_sync_r[0], lock_detect};
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_sync_r <= '0;
        end else if (clk_en) begin
            lock_sync_r <= lock_sync_nxt;
        end
    end

    // pin mux between readback and lock
    assign link.readback_out_pin = (readback_pin_select == PIN_SEL_READBACK)
                                   ? out_bit_r : lock_sync_r[1];

    // system domain: toggle crossing of completed writes
    logic [2:0]            sync_r, sync_nxt;
    logic                  wr_valid_r, wr_valid_nxt;
    logic [FRAME_BITS-1:0] wr_r, wr_nxt;
    logic                  wr_land;

    always_comb begin
        sync_nxt     = {sync_r[1:0], done_tgl_r};
        wr_land      = sync_r[2] ^ sync_r[1];
        wr_valid_nxt = wr_land;
        wr_nxt       = wr_r;
        // hold_r stable long before toggle lands
        if (wr_land) begin
            wr_nxt = hold_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_r     <= '0;
            wr_valid_r <= 1'b0;
            wr_r       <= '0;
        end else if (clk_en) begin
            sync_r     <= sync_nxt;
            wr_valid_r <= wr_valid_nxt;
            wr_r       <= wr_nxt;
        end
    end

    // flag zero frames only reach here
    assign wr_valid = wr_valid_r;
    assign wr_addr  = wr_r[FRAME_BITS-2 -: ADDR_BITS];
    assign wr_data  = wr_r[DATA_BITS-1:0];
endmodule // prog_port_dev

// ### prog_port_host.sv
/*
 * host end: drives 24-bit frames in mode zero from a divided clk,
 * returns readback data. assumes one device on the link.
 */
`timescale 1ns/1ps
module prog_port_host
    import prog_port_pkg::*;
#(
    parameter int HALF_PERIOD = HALF_PERIOD_DEF
) (
    // system side
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    // command
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_read,
    input  wire logic [ADDR_BITS-1:0] cmd_addr,
    input  wire logic [DATA_BITS-1:0] cmd_data,
    output logic                      cmd_ready,
    output logic                      rsp_valid,
    output logic      [DATA_BITS-1:0] rsp_data,
    // link
    prog_port_if.host                 link
);
    import prog_port_pkg::*;

    typedef enum {IDLE, LOW, HIGH, GAP} hst_t;
    hst_t state_r, state_nxt;
    logic [FRAME_BITS-1:0] sh_r, sh_nxt;
    logic [DATA_BITS-1:0]  rx_r, rx_nxt;
    logic [CNT_BITS-1:0]   bit_r, bit_nxt;
    logic [7:0]            div_r, div_nxt;
    logic                  rd_r, rd_nxt, rv_r, rv_nxt;
    logic [1:0]            miso_r, miso_nxt;

    localparam logic [7:0] HP = 8'(HALF_PERIOD - 1);

    always_comb begin
        state_nxt = state_r;
        sh_nxt    = sh_r;
        rx_nxt    = rx_r;
        bit_nxt   = bit_r;
        rd_nxt    = rd_r;
        rv_nxt    = 1'b0;
        miso_nxt  = {miso_r[0], link.readback_out_pin};
        div_nxt   = (div_r == HP) ? 8'h00 : div_r + 8'h01;
        case (state_r)
            IDLE: begin
                div_nxt = 8'h00;
                if (cmd_valid) begin
                    sh_nxt    = {cmd_read ? FLAG_READ : FLAG_WRITE, cmd_addr, cmd_data};
                    rd_nxt    = cmd_read;
                    bit_nxt   = '0;
                    state_nxt = LOW;
                end
            end
            LOW: if (div_r == HP) state_nxt = HIGH;
            HIGH: begin
                if (div_r == HP) begin
                    sh_nxt  = {sh_r[FRAME_BITS-2:0], 1'b0};
                    bit_nxt = bit_r + 5'h01;
                    // sample late in high half, settled
                    if (bit_r >= ADDR_END_CNT) rx_nxt = {rx_r[DATA_BITS-2:0], miso_r[1]};
                    state_nxt = (bit_nxt == FRAME_END_CNT) ? GAP : LOW;
                end
            end
            GAP: if (div_r == HP) begin
                rv_nxt    = rd_r;
                state_nxt = IDLE;
            end
            default: state_nxt = IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= IDLE;
            sh_r    <= '0;
            rx_r    <= '0;
            bit_r   <= '0;
            div_r   <= '0;
            rd_r    <= 1'b0;
            rv_r    <= 1'b0;
            miso_r  <= '0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            sh_r    <= sh_nxt;
            rx_r    <= rx_nxt;
            bit_r   <= bit_nxt;
            div_r   <= div_nxt;
            rd_r    <= rd_nxt;
            rv_r    <= rv_nxt;
            miso_r  <= miso_nxt;
        end
    end

    // select low only inside a frame
    assign link.select_bar_in  = (state_r == IDLE);
    assign link.sclk           = (state_r == HIGH);
    assign link.serial_data_in = sh_r[FRAME_BITS-1];
    assign cmd_ready           = (state_r == IDLE);
    assign rsp_valid           = rv_r;
    assign rsp_data            = rx_r;
endmodule // prog_port_host

// ### prog_port_monitor.sv
/*
 * checker on the programming link between host and device ends.
 * assumes sclk is made from clk by the host divider, mode zero.
 */
`timescale 1ns/1ps
module prog_port_monitor (
    // system
    input wire logic clk,
    input wire logic rst_b,
    // link
    input wire logic sclk,
    input wire logic select_bar_in,
    input wire logic serial_data_in,
    input wire logic readback_out_pin,
    // pin mux
    input wire logic readback_pin_select,
    input wire logic lock_detect
);
    logic [4:0] n_r;
    logic       rd_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // rises in this frame; flag kept from the first
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            n_r <= 5'h00;
            rd_r <= 1'b0;
        end else if (select_bar_in) begin
            n_r <= 5'h00;
        end else if ($rose(sclk)) begin
            n_r <= n_r + 5'h01;
            if (n_r == 5'h00)
                rd_r <= serial_data_in;
        end
    end
    sequence s_frame_end;
        ##[1:400] $rose(select_bar_in);
    endsequence
    sequence s_release;
        ##[1:8] $rose(select_bar_in);
    endsequence
    a_frame_release: assert property ($fell(sclk) && n_r == 5'h18 |-> s_release)
        else $error("select kept low after frame");
    a_frame_bounded: assert property ($fell(select_bar_in) |-> s_frame_end)
        else $error("frame not closed");
    a_frame_count: assert property ($rose(select_bar_in) |-> n_r == 5'h18)
        else $error("frame not 24 clocks");
    a_idle_clock_low: assert property (select_bar_in |-> !sclk)
        else $error("clock while deselected");
    a_clock_selected: assert property ($rose(sclk) |-> !$past(select_bar_in))
        else $error("clock before select");
    a_data_held_rise: assert property (!select_bar_in && $rose(sclk) |-> $stable(serial_data_in))
        else $error("data moved at rise");
    a_deselect_gap: assert property ($rose(select_bar_in) |-> !sclk && !$past(sclk))
        else $error("deselect gap short");
    a_addr_pin_low: assert property (!select_bar_in && rd_r && n_r inside {[1:7]}
        && !readback_pin_select |-> !readback_out_pin)
        else $error("pin high in address");
    a_pin_on_fall: assert property ($changed(readback_out_pin) && !select_bar_in
        && !readback_pin_select |-> !sclk)
        else $error("pin moved not after fall");
    a_lock_mux: assert property ((readback_pin_select && lock_detect)[*4] |-> readback_out_pin)
        else $error("lock not on pin");
endmodule // prog_port_monitor

// ### tb_synth_serial_program_port.sv
/*
 * bench joining host and device ends over the programming link.
 * assumes both ends share clk; sclk comes from the host divider.
 */
`timescale 1ns/1ps
module tb_synth_serial_program_port;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        cmd_read = 1'b0;
    logic [6:0]  cmd_addr = 7'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic        readback_pin_select = 1'b0;
    logic        lock_detect = 1'b0;
    logic        cmd_ready, rsp_valid, wr_valid;
    logic [15:0] rsp_data, wr_data, rd_data;
    logic [6:0]  rd_addr, wr_addr;
    int          n_fail = 0, n_tests = 0, n_wr = 0, cyc = 0;
    prog_port_if link_if ();
    // register file stand-in, address-derived so each read differs
    assign rd_data = {rd_addr, 2'h2, ~rd_addr};
    prog_port_host u_prog_port_host (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link_if));
    prog_port_dev u_prog_port_dev (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .link(link_if),
        .readback_pin_select(readback_pin_select), .lock_detect(lock_detect),
        .rd_data(rd_data), .rd_addr(rd_addr), .wr_valid(wr_valid), .wr_addr(wr_addr),
        .wr_data(wr_data));
    prog_port_monitor u_prog_port_monitor (.clk(clk), .rst_b(rst_b), .sclk(link_if.sclk),
        .select_bar_in(link_if.select_bar_in), .serial_data_in(link_if.serial_data_in),
        .readback_out_pin(link_if.readback_out_pin),
        .readback_pin_select(readback_pin_select), .lock_detect(lock_detect));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (wr_valid === 1'b1)
            n_wr++;
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one frame; returns once the write lands or the read answers
    task automatic send(input logic rd, input logic [6:0] a, input logic [15:0] d);
        int w0;
        w0 = n_wr;
        @(posedge clk);
        #1;
        while (cmd_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_addr = a;
        cmd_data = d;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        while (rd ? rsp_valid !== 1'b1 : n_wr == w0) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic t_write();
        send(1'b0, 7'h7F, 16'hA5C3);
        chk({9'h0, wr_addr}, 16'h007F);
        chk(wr_data, 16'hA5C3);
        send(1'b0, 7'h00, 16'h5A3C);
        chk({9'h0, wr_addr}, 16'h0000);
        chk(wr_data, 16'h5A3C);
    endtask
    // data bits that would move the address if they were shifted in
    task automatic addr_held(input logic [6:0] a);
        repeat (24) @(posedge link_if.sclk);
        #1;
        chk({9'h0, rd_addr}, {9'h0, a});
    endtask
    task automatic t_read();
        int w0;
        w0 = n_wr;
        fork
            send(1'b1, 7'h55, 16'hFFFF);
            addr_held(7'h55);
        join
        chk(rsp_data, {7'h55, 2'h2, 7'h2A});
        fork
            send(1'b1, 7'h2A, 16'h0000);
            addr_held(7'h2A);
        join
        chk(rsp_data, {7'h2A, 2'h2, 7'h55});
        chk(16'(n_wr - w0), 16'h0000);
    endtask
    // mux switched only between frames
    task automatic t_lock();
        readback_pin_select = 1'b1;
        for (int v = 0; v < 2; v++) begin
            lock_detect = v[0];
            repeat (6) @(posedge clk);
            #1;
            chk({15'h0, link_if.readback_out_pin}, {15'h0, v[0]});
        end
        readback_pin_select = 1'b0;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_write();
        t_read();
        t_lock();
        t_read();
        conclude();
    end
endmodule // tb_synth_serial_program_port
